// ===== power_mode_control.sv
// power mode control: supply, regulator, halver and LCD power registers
// assumes a same-clock register port; read data one cycle after read strobe
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module power_mode_control #(
	parameter int LCD_SETTLE = power_mode_pkg::LCD_SETTLE_CYC,
	parameter int REG_SETTLE = power_mode_pkg::REG_SETTLE_CYC,
	parameter bit EXT_LCD_SUPPLY = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [15:0] addr,
	input wire logic [3:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [3:0] rdata_r,
	// supply controls
	output logic logic_supply_select_r,
	output logic fast_regulator_on_r,
	output logic slow_regulator_halver_r,
	output logic lcd_supply_halver_r,
	// clock controls
	output logic cpu_clock_select_r,
	output logic fast_osc_run_r,
	// lcd supply and drive
	output logic lcd_supply_enable_r,
	output logic lcd_drive_ground_r,
	output logic [3:0] contrast_level_r,
	output logic lcd_static_drive_r,
	output logic [1:0] lcd_duty_r,
	// always-on circuits
	output logic always_on_r,
	// status
	output logic lcd_settled_r,
	output logic regulator_settled_r
);
	logic [3:0] psc_r;
	logic [3:0] lcd_r;
	logic [3:0] clk_ctl_r;
	logic wr_psc, wr_lcd, wr_clk, wr_con;
	logic lcd_on_pulse, reg_on_pulse;
	logic lcd_done, reg_done;
	logic [3:0] rdata_nxt;

	assign wr_psc = wr && addr == power_mode_pkg::PSC_ADDR;
	assign wr_lcd = wr && addr == power_mode_pkg::LCD_ADDR;
	assign wr_clk = wr && addr == power_mode_pkg::CLK_ADDR;
	assign wr_con = wr && addr == power_mode_pkg::CON_ADDR;

	// supply control register; reset values give normal, slow operation
	always_ff @(posedge clk) begin
		if (rst)
			psc_r <= power_mode_pkg::PSC_RESET; // see R15
		else if (wr_psc)
			psc_r <= wdata; // see R1 // see R2 // see R4 // see R5
	end

	// no interlock on R3/R6/R11/R12: software owns the ordering
	always_ff @(posedge clk) begin
		if (rst)
			lcd_r <= power_mode_pkg::LCD_RESET; // see R15
		else if (wr_lcd)
			lcd_r <= wdata; // see R13 // see R19
	end

	always_ff @(posedge clk) begin
		if (rst)
			clk_ctl_r <= power_mode_pkg::CLK_RESET; // see R15
		else if (wr_clk)
			clk_ctl_r <= wdata & 4'h3;
	end

	// contrast: 16 levels across the base voltage span
	always_ff @(posedge clk) begin
		if (rst)
			contrast_level_r <= power_mode_pkg::CON_RESET;
		else if (wr_con)
			contrast_level_r <= wdata; // see R16
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			logic_supply_select_r <= 1'b0;
			fast_regulator_on_r <= 1'b0;
			slow_regulator_halver_r <= 1'b0;
			lcd_supply_halver_r <= 1'b0;
			cpu_clock_select_r <= 1'b0;
			fast_osc_run_r <= 1'b0;
		end else begin
			logic_supply_select_r <= psc_r[power_mode_pkg::LOGIC_SEL_BIT]; // see R1
			fast_regulator_on_r <= psc_r[power_mode_pkg::FAST_REG_BIT]; // see R2
			slow_regulator_halver_r <= psc_r[power_mode_pkg::SLOW_HALV_BIT]; // see R4
			lcd_supply_halver_r <= psc_r[power_mode_pkg::LCD_HALV_BIT]; // see R5
			cpu_clock_select_r <= clk_ctl_r[power_mode_pkg::CPU_CLK_BIT];
			fast_osc_run_r <= clk_ctl_r[power_mode_pkg::OSC_RUN_BIT];
		end
	end

	// external supply option keeps the internal circuit off
	always_ff @(posedge clk) begin
		if (rst) begin
			lcd_supply_enable_r <= 1'b0;
			lcd_drive_ground_r <= 1'b1;
			lcd_static_drive_r <= 1'b0;
			lcd_duty_r <= 2'h0;
		end else begin
			lcd_supply_enable_r <= lcd_r[power_mode_pkg::LCD_PWR_BIT]
				&& !EXT_LCD_SUPPLY; // see R17
			lcd_drive_ground_r <= !lcd_r[power_mode_pkg::LCD_PWR_BIT]; // see R13
			lcd_static_drive_r <= lcd_r[power_mode_pkg::STATIC_BIT]; // see R19
			lcd_duty_r <= {lcd_r[power_mode_pkg::DUTY_HI_BIT],
				lcd_r[power_mode_pkg::DUTY_LO_BIT]}; // see R19
		end
	end

	// voltage halver and slow regulators never switch off
	always_ff @(posedge clk) begin
		if (rst)
			always_on_r <= 1'b1;
		else
			always_on_r <= 1'b1; // see R18
	end

	// settle status helps software honour its wait times
	assign lcd_on_pulse = wr_lcd && wdata[power_mode_pkg::LCD_PWR_BIT]
		&& !lcd_r[power_mode_pkg::LCD_PWR_BIT];
	assign reg_on_pulse = wr_psc && wdata[power_mode_pkg::LOGIC_SEL_BIT]
		&& !psc_r[power_mode_pkg::LOGIC_SEL_BIT];

	settle_timer #(.COUNT(LCD_SETTLE), .W(32)) lcd_tmr (
		.clk(clk),
		.rst(rst),
		.start(lcd_on_pulse),
		.abort(wr_lcd && !wdata[power_mode_pkg::LCD_PWR_BIT]),
		.done_r(lcd_done)
	); // see R14

	settle_timer #(.COUNT(REG_SETTLE), .W(32)) reg_tmr (
		.clk(clk),
		.rst(rst),
		.start(reg_on_pulse),
		.abort(wr_psc && !wdata[power_mode_pkg::LOGIC_SEL_BIT]),
		.done_r(reg_done)
	); // see R8

	always_ff @(posedge clk) begin
		if (rst) begin
			lcd_settled_r <= 1'b0;
			regulator_settled_r <= 1'b0;
		end else begin
			lcd_settled_r <= lcd_done;
			regulator_settled_r <= reg_done;
		end
	end

	always_comb begin
		rdata_nxt = 4'h0;
		case (addr)
			power_mode_pkg::PSC_ADDR: rdata_nxt = psc_r;
			power_mode_pkg::LCD_ADDR: rdata_nxt = lcd_r;
			power_mode_pkg::CLK_ADDR: rdata_nxt = clk_ctl_r;
			power_mode_pkg::CON_ADDR: rdata_nxt = contrast_level_r;
			power_mode_pkg::STA_ADDR: rdata_nxt = {2'h0, reg_done, lcd_done};
			default: rdata_nxt = 4'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata_r <= 4'h0;
		else if (rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= 4'h0;
	end

	reset_state_a: assert property (@(posedge clk)
		$fell(rst) |-> !fast_regulator_on_r && !logic_supply_select_r
		&& !lcd_supply_enable_r) else $error("reset state wrong"); // see R15
	supply_follow_a: assert property (@(posedge clk) disable iff (rst)
		wr_psc |=> ##1 logic_supply_select_r == $past(wdata[0], 2))
		else $error("logic supply not following write"); // see R1
	regulator_follow_a: assert property (@(posedge clk) disable iff (rst)
		wr_psc |=> ##1 fast_regulator_on_r == $past(wdata[1], 2))
		else $error("fast regulator not following write"); // see R2
	slow_halver_a: assert property (@(posedge clk) disable iff (rst)
		wr_psc |=> ##1 slow_regulator_halver_r == $past(wdata[2], 2))
		else $error("slow halver not following write"); // see R4
	lcd_halver_a: assert property (@(posedge clk) disable iff (rst)
		wr_psc |=> ##1 lcd_supply_halver_r == $past(wdata[3], 2))
		else $error("lcd halver not following write"); // see R5
	lcd_ground_a: assert property (@(posedge clk) disable iff (rst)
		lcd_drive_ground_r |-> !lcd_supply_enable_r)
		else $error("lcd grounded while enabled"); // see R13
	ext_supply_a: assert property (@(posedge clk) disable iff (rst)
		EXT_LCD_SUPPLY |-> !lcd_supply_enable_r)
		else $error("internal lcd supply on with external option"); // see R17
	always_on_a: assert property (@(posedge clk) disable iff (rst)
		always_on_r) else $error("always-on circuits stopped"); // see R18
	static_drive_a: assert property (@(posedge clk) disable iff (rst)
		wr_lcd |=> ##1 lcd_static_drive_r == $past(wdata[3], 2))
		else $error("static drive not following write"); // see R19
	contrast_a: assert property (@(posedge clk) disable iff (rst)
		wr_con |=> contrast_level_r == $past(wdata))
		else $error("contrast not stored"); // see R16

	// a write lands in its register at once and on the pins a cycle later
	sequence psc_store_s;
		wr_psc ##1 1'b1;
	endsequence

	sequence lcd_store_s;
		wr_lcd ##1 1'b1;
	endsequence

	sequence lcd_pin_s;
		wr_lcd ##2 1'b1;
	endsequence

	sequence clk_pin_s;
		wr_clk ##2 1'b1;
	endsequence

	psc_store_a: assert property (@(posedge clk) disable iff (rst)
		psc_store_s |-> psc_r == $past(wdata))
		else $error("supply register not stored"); // see R1
	lcd_store_a: assert property (@(posedge clk) disable iff (rst)
		lcd_store_s |-> lcd_r == $past(wdata))
		else $error("lcd register not stored"); // see R13
	lcd_enable_a: assert property (@(posedge clk) disable iff (rst)
		lcd_pin_s |-> lcd_supply_enable_r ==
		($past(wdata[0], 2) && !EXT_LCD_SUPPLY))
		else $error("lcd supply enable not following write"); // see R13
	ground_follow_a: assert property (@(posedge clk) disable iff (rst)
		lcd_pin_s |-> lcd_drive_ground_r == !$past(wdata[0], 2))
		else $error("lcd ground not following write"); // see R13
	lcd_duty_a: assert property (@(posedge clk) disable iff (rst)
		lcd_pin_s |-> lcd_duty_r == $past(wdata[2:1], 2))
		else $error("lcd duty not following write"); // see R19
	cpu_clock_a: assert property (@(posedge clk) disable iff (rst)
		clk_pin_s |-> cpu_clock_select_r == $past(wdata[0], 2))
		else $error("cpu clock select not following write"); // see R8
	osc_run_a: assert property (@(posedge clk) disable iff (rst)
		clk_pin_s |-> fast_osc_run_r == $past(wdata[1], 2))
		else $error("fast osc run not following write"); // see R8

	// status may only stand while the circuit it reports is still on
	reg_settle_a: assert property (@(posedge clk) disable iff (rst)
		regulator_settled_r |-> logic_supply_select_r)
		else $error("regulator settled while logic voltage low"); // see R8
	lcd_settle_a: assert property (@(posedge clk) disable iff (rst)
		lcd_settled_r |-> !lcd_drive_ground_r)
		else $error("lcd settled while drive grounded"); // see R14

	// read port: zero unless the previous cycle strobed a read
	read_idle_a: assert property (@(posedge clk) disable iff (rst)
		!rd |=> rdata_r == 4'h0)
		else $error("read data not idle"); // see R1
	read_psc_a: assert property (@(posedge clk) disable iff (rst)
		rd && addr == power_mode_pkg::PSC_ADDR |=> rdata_r == $past(psc_r))
		else $error("supply register read wrong"); // see R1
	read_lcd_a: assert property (@(posedge clk) disable iff (rst)
		rd && addr == power_mode_pkg::LCD_ADDR |=> rdata_r == $past(lcd_r))
		else $error("lcd register read wrong"); // see R13
	reset_out_a: assert property (@(posedge clk)
		rst |=> rdata_r == 4'h0 && lcd_drive_ground_r && always_on_r
		&& !lcd_settled_r && !regulator_settled_r)
		else $error("outputs not reset"); // see R15
endmodule

// ===== power_mode_pkg.sv
// power mode control constants: register map, field positions, resets
// assumes a 4-bit register port with byte-style addresses, 125 MHz clock
//
// What the document requires
// R1: logic_supply_select bit picks high-speed (1) or low-speed (0) logic voltage.
// R2: fast_regulator_on bit starts (1) or stops (0) the fast regulator.
// R3: software never clears fast_regulator_on while running on the fast clock.
// R4: slow_regulator_halver bit feeds slow regulator from half supply when 1.
// R5: lcd_supply_halver bit feeds LCD supply circuit from half supply when 1.
// R6: halver modes only with supply at least 2.4 V, never on fast clock.
// R7: before LCD halver, check supply and set contrast level 6 or less.
// R8: fast entry: halver off, regulator on, logic high, wait, osc on, wait, clock.
// R9: halver entry: slow clock, osc off, logic low, regulator off, check, halver.
// R10: first four halver-entry steps needed only during fast operation.
// R11: software stops the fast oscillator before selecting low-speed logic voltage.
// R12: slow regulator returns to normal mode before high-speed logic voltage.
// R13: lcd_power_on enables LCD drive voltages; 0 grounds them all.
// R14: allow about 100 msec after LCD power on before relying on display.
// R15: reset gives normal modes, regulator off, low voltage, LCD off, slow clock.
// R16: LCD base voltage adjustable over 16 levels, 0.95 V to 1.40 V.
// R17: external LCD supply option keeps internal LCD supply inactive always.
// R18: halver, oscillator and slow regulators run always, independent of mode bits.
// R19: static-drive bit selects static (1) or dynamic (0); two-bit duty field.
package power_mode_pkg;
	localparam logic [15:0] PSC_ADDR = 16'hFF00;
	localparam logic [15:0] LCD_ADDR = 16'hFF60;
	localparam logic [15:0] CLK_ADDR = 16'hFF01;
	localparam logic [15:0] CON_ADDR = 16'hFF02;
	localparam logic [15:0] STA_ADDR = 16'hFF03;
	// power_supply_control fields
	localparam int LOGIC_SEL_BIT = 0;
	localparam int FAST_REG_BIT = 1;
	localparam int SLOW_HALV_BIT = 2;
	localparam int LCD_HALV_BIT = 3;
	// lcd_drive_power_control fields
	localparam int LCD_PWR_BIT = 0;
	localparam int DUTY_LO_BIT = 1;
	localparam int DUTY_HI_BIT = 2;
	localparam int STATIC_BIT = 3;
	// clock control fields
	localparam int CPU_CLK_BIT = 0;
	localparam int OSC_RUN_BIT = 1;
	localparam logic [3:0] PSC_RESET = 4'h0;
	localparam logic [3:0] LCD_RESET = 4'h0;
	localparam logic [3:0] CLK_RESET = 4'h0;
	localparam logic [3:0] CON_RESET = 4'h0;
	// settle times
	localparam int CLK_MHZ = 125;
	localparam int LCD_SETTLE_MS = 100;
	localparam int LCD_SETTLE_CYC = LCD_SETTLE_MS * 1000 * CLK_MHZ;
	localparam int REG_SETTLE_US = 2500;
	localparam int REG_SETTLE_CYC = REG_SETTLE_US * CLK_MHZ;
endpackage

// ===== settle_timer.sv
// settle timer: counts a fixed number of cycles after a start pulse
// assumes start is a one-cycle pulse on clk; restarts on every start unless abort is high in the same cycle
`timescale 1ns/1ns
module settle_timer #(
	parameter int COUNT = 16,
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start,
	input wire logic abort,
	output logic done_r
);
	logic [W-1:0] cnt_r;
	logic busy_r;

	always_ff @(posedge clk) begin
		if (rst || abort) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (start) begin
			cnt_r <= W'(COUNT - 1);
			busy_r <= 1'b1;
		end else if (busy_r && cnt_r != '0) begin
			cnt_r <= cnt_r - W'(1);
		end else begin
			busy_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || abort || start)
			done_r <= 1'b0;
		else if (busy_r && cnt_r == '0)
			done_r <= 1'b1;
	end
endmodule

// ===== tb_top.sv
// self-checking bench for power_mode_control: reads scored through a queue
// assumes the design package is compiled first; settle counts cut short
`timescale 1ns/1ns
module tb_top;
	localparam int LCD_N = 20;
	localparam int REG_N = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [3:0] wdata = 4'h0;
	logic [3:0] v;
	logic [3:0] rdata_r, contrast_level_r;
	logic [1:0] lcd_duty_r;
	logic logic_supply_select_r, fast_regulator_on_r, slow_regulator_halver_r;
	logic lcd_supply_halver_r, cpu_clock_select_r, fast_osc_run_r;
	logic lcd_supply_enable_r, lcd_drive_ground_r, lcd_static_drive_r;
	logic always_on_r, lcd_settled_r, regulator_settled_r;
	logic [3:0] exp_q[$];
	int mismatches = 0;
	int check_count = 0;
	int n;

	power_mode_control #(.LCD_SETTLE(LCD_N), .REG_SETTLE(REG_N),
		.EXT_LCD_SUPPLY(1'b0)) power_mode_control_inst (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_r(rdata_r), .logic_supply_select_r(logic_supply_select_r),
		.fast_regulator_on_r(fast_regulator_on_r),
		.slow_regulator_halver_r(slow_regulator_halver_r),
		.lcd_supply_halver_r(lcd_supply_halver_r),
		.cpu_clock_select_r(cpu_clock_select_r),
		.fast_osc_run_r(fast_osc_run_r),
		.lcd_supply_enable_r(lcd_supply_enable_r),
		.lcd_drive_ground_r(lcd_drive_ground_r),
		.contrast_level_r(contrast_level_r),
		.lcd_static_drive_r(lcd_static_drive_r), .lcd_duty_r(lcd_duty_r),
		.always_on_r(always_on_r), .lcd_settled_r(lcd_settled_r),
		.regulator_settled_r(regulator_settled_r));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic complete_run;
		if (exp_q.size() != 0)
			mismatches++;
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, input logic [3:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	// bounded wait on a settle flag, window around the shortened count
	task automatic wait_settle(input bit sel, input int lo, input int hi);
		n = 0;
		while ((sel ? regulator_settled_r : lcd_settled_r) !== 1'b1) begin
			tick(1);
			n++;
			if (n > 200) begin
				mismatches++;
				complete_run();
			end
		end
		chk({3'h0, n >= lo && n <= hi}, 4'h1);
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d && exp_q.size() > 0)
			chk(rdata_r, exp_q.pop_front());
	end

	initial begin
		v = 4'($urandom(55765));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		chk({lcd_drive_ground_r, always_on_r, 2'h0}, 4'hC);
		chk({fast_osc_run_r, cpu_clock_select_r, lcd_supply_enable_r,
			fast_regulator_on_r}, 4'h0);
		rd_reg(power_mode_pkg::PSC_ADDR, power_mode_pkg::PSC_RESET);
		rd_reg(power_mode_pkg::LCD_ADDR, power_mode_pkg::LCD_RESET);
		rd_reg(power_mode_pkg::CLK_ADDR, power_mode_pkg::CLK_RESET);
		repeat (8) begin
			v = 4'($urandom);
			wr_reg(power_mode_pkg::PSC_ADDR, v);
			tick(1);
			chk({lcd_supply_halver_r, slow_regulator_halver_r,
				fast_regulator_on_r, logic_supply_select_r}, v);
			rd_reg(power_mode_pkg::PSC_ADDR, v);
			v = 4'($urandom);
			wr_reg(power_mode_pkg::LCD_ADDR, v);
			tick(1);
			chk({lcd_static_drive_r, lcd_duty_r, lcd_supply_enable_r}, v);
			chk({3'h0, lcd_drive_ground_r}, {3'h0, ~v[0]});
			rd_reg(power_mode_pkg::LCD_ADDR, v);
			wr_reg(power_mode_pkg::CLK_ADDR, v);
			tick(1);
			chk({2'h0, fast_osc_run_r, cpu_clock_select_r}, {2'h0, v[1:0]});
			rd_reg(power_mode_pkg::CLK_ADDR, {2'h0, v[1:0]});
		end
		for (int i = 0; i < 16; i++) begin
			wr_reg(power_mode_pkg::CON_ADDR, i[3:0]);
			tick(0);
			chk(contrast_level_r, i[3:0]);
			rd_reg(power_mode_pkg::CON_ADDR, i[3:0]);
		end
		// unmapped place: write ignored, read gives zero
		wr_reg(16'hFF05, 4'hF);
		rd_reg(16'hFF05, 4'h0);
		wr_reg(power_mode_pkg::LCD_ADDR, 4'h0);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h0);
		tick(3);
		wr_reg(power_mode_pkg::LCD_ADDR, 4'h1);
		wait_settle(1'b0, LCD_N - 5, LCD_N + 5);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h3);
		wait_settle(1'b1, REG_N - 5, REG_N + 5);
		rd_reg(power_mode_pkg::STA_ADDR, 4'h3);
		// fast entry from slow operation, steps in order except no wait between osc on and clock
		wr_reg(power_mode_pkg::CLK_ADDR, 4'h0);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h0);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h2);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h3);
		wait_settle(1'b1, REG_N - 5, REG_N + 5);
		wr_reg(power_mode_pkg::CLK_ADDR, 4'h2);
		wr_reg(power_mode_pkg::CLK_ADDR, 4'h3);
		tick(1);
		chk({cpu_clock_select_r, fast_osc_run_r, fast_regulator_on_r,
			logic_supply_select_r}, 4'hF);
		// halver entry from fast operation; supply check has no model here
		wr_reg(power_mode_pkg::CLK_ADDR, 4'h2);
		wr_reg(power_mode_pkg::CLK_ADDR, 4'h0);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h2);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'h0);
		wr_reg(power_mode_pkg::CON_ADDR, 4'h6);
		wr_reg(power_mode_pkg::PSC_ADDR, 4'hC);
		tick(1);
		chk({lcd_supply_halver_r, slow_regulator_halver_r,
			fast_regulator_on_r, logic_supply_select_r}, 4'hC);
		chk({cpu_clock_select_r, fast_osc_run_r, regulator_settled_r,
			lcd_settled_r}, 4'h1);
		rd_reg(power_mode_pkg::STA_ADDR, 4'h1);
		// second reset in mid-run with nonzero registers
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		chk({lcd_drive_ground_r, lcd_supply_enable_r, logic_supply_select_r,
			fast_regulator_on_r}, 4'h8);
		rd_reg(power_mode_pkg::PSC_ADDR, power_mode_pkg::PSC_RESET);
		rd_reg(power_mode_pkg::LCD_ADDR, power_mode_pkg::LCD_RESET);
		rd_reg(power_mode_pkg::STA_ADDR, 4'h0);
		tick(4);
		complete_run();
	end
endmodule
